// file: sar_regs.vh
// offsets, fields, reset values and counts of the successive approximation register
`ifndef SAR_REGS_VH
`define SAR_REGS_VH

// register byte offsets on the avalon slave
`define SAR_CTRL_OFS        4'h0
`define SAR_STATUS_OFS      4'h4

// control register fields
`define SAR_CTRL_MODE_BIT   0
`define SAR_CTRL_START_BIT  1
`define SAR_CTRL_RESET      32'h00000000

// status register fields
`define SAR_STAT_RES_LSB    0
`define SAR_STAT_EOC_BIT    8
`define SAR_STAT_BUSY_BIT   9
`define SAR_STAT_SOUT_BIT   10

// result word
`define SAR_WIDTH           8
`define SAR_RESULT_RESET    8'h00

// comparator input stage depth
`define SAR_SYNC_STAGES     2

`endif

// file: sar_cmp_input.v
// comparator decision input stage: synchroniser and hysteresis filter
`default_nettype none

module sar_cmp_input #(
   parameter FILTER = 1
) (
   input  wire CLK,
   input  wire RSTN,
   input  wire COMP_IN,
   output reg  COMP_OUT
);

   reg meta_reg;   // first stage, read only by sync_reg
   reg sync_reg;
   reg prev_reg;

   // two-flop synchroniser, then a change is accepted only when two samples agree
   always @(posedge CLK) begin
      if (!RSTN) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
         COMP_OUT <= 1'b0;
      end else begin
         meta_reg <= COMP_IN;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         if (FILTER == 0 || sync_reg == prev_reg) begin
            COMP_OUT <= sync_reg;
         end
      end
   end

endmodule // sar_cmp_input

`default_nettype wire

// file: sar_core.v
// successive approximation register with avalon-mm control and status
//
// Summary of operation
// - all inputs are captured on rising clock edges; RSTN is also sampled on falling edges for end_of_convert.
// - start_convert low then high on consecutive edges starts a conversion.
// - comparator decision passes a hysteresis stage and synchroniser first.
// - clear_hold asserted clears result and serial output at the next rising edge; end_of_convert clears at the falling edge after it.
// - after clear_hold releases with start_convert low, stay cleared until it goes high.
// - result bits set high in turn, then cleared by comparator decision.
// - a decided bit holds until clear or new conversion.
// - end_of_convert rises on falling edge after last decision or register_shorten.
// - serial output shows each bit in the period it is decided.
// - serial output low in initial period, while cleared, second cycle after end.
// - serial inhibit inactive one cycle after end; starts inhibited for cascading.
// - with end_of_convert low and clocking, only the cleared state is stable.
// - shortening variant recirculates after end when start_convert is high.
// - end_of_convert fed back to start_convert gives free running.
// - word of at most eight bits; wider words by cascading two.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`default_nettype none
`include "sar_regs.vh"

module sar_core #(
   parameter WIDTH  = `SAR_WIDTH,
   parameter FILTER = 1
) (
   input  wire             CLK,
   input  wire             RSTN,
   input  wire             START_CONVERT,
   input  wire             CLEAR_HOLD,
   input  wire             REGISTER_SHORTEN,
   input  wire             COMP_DATA,
   output reg  [WIDTH-1:0] RESULT,
   output reg              SERIAL_OUT,
   output reg              END_OF_CONVERT,
   input  wire [3:0]       AVS_ADDRESS,
   input  wire             AVS_READ,
   input  wire             AVS_WRITE,
   input  wire [31:0]      AVS_WRITEDATA,
   output reg  [31:0]      AVS_READDATA,
   output reg              AVS_WAITREQUEST
);

   // one-hot sequencer states
   localparam [4:0] ST_IDLE  = 5'b00001;
   localparam [4:0] ST_TRIAL = 5'b00010;
   localparam [4:0] ST_DONE1 = 5'b00100;
   localparam [4:0] ST_DONE2 = 5'b01000;
   localparam [4:0] ST_DONE  = 5'b10000;

   // next trial mask: move the trial bit one place toward the lsb
   function [WIDTH-1:0] next_mask;
      input [WIDTH-1:0] mask;
      begin
         next_mask = mask >> 1;
      end
   endfunction

   // decide the current bit and raise the next one
   function [WIDTH-1:0] decide;
      input [WIDTH-1:0] res;
      input [WIDTH-1:0] mask;
      input             keep;
      begin
         decide = (res & ~mask) | (keep ? mask : {WIDTH{1'b0}}) | next_mask(mask);
      end
   endfunction

   wire             cmp_dec;           // filtered, synchronised comparator decision
   reg  [4:0]       state_reg;
   reg  [4:0]       state_next;
   reg  [WIDTH-1:0] mask_reg;
   reg  [WIDTH-1:0] mask_next;
   reg  [WIDTH-1:0] result_next;
   reg              sout_next;
   reg              sc_prev_reg;
   reg              eoc_flag_reg;      // set by the final decision edge
   reg              eoc_flag_next;
   reg              mode_shorten_reg;  // 1: pin acts as register_shorten, 0: clear_hold
   reg              soft_start_reg;
   reg              start;
   reg              clear;
   reg              last;
   wire             req;
   wire             take;
   wire [8:0]       result_pad;        // result widened to the status byte, one spare bit on top

   // zero-extend the result so the status word keeps its layout for any width up to eight
   assign result_pad = {{(9-WIDTH){1'b0}}, RESULT};

   // comparator decision stage
   sar_cmp_input #(
      .FILTER   (FILTER)
   ) u_cmp (
      .CLK      (CLK),
      .RSTN     (RSTN),
      .COMP_IN  (COMP_DATA),
      .COMP_OUT (cmp_dec)
   );

   // start and clear decode, all from edge-sampled inputs
   always @* begin
      clear = !mode_shorten_reg && CLEAR_HOLD;
      start = (START_CONVERT && !sc_prev_reg) || soft_start_reg;
      // the cleared state is left once start_convert is high, or at once in shortening mode
      if (state_reg == ST_IDLE && (START_CONVERT || mode_shorten_reg)) begin
         start = 1'b1;
      end
      // shortening variant recirculates when start_convert stays high
      if (mode_shorten_reg && START_CONVERT &&
          (state_reg == ST_DONE1 || state_reg == ST_DONE2 || state_reg == ST_DONE)) begin
         start = 1'b1;
      end
      // last trial: lsb decided or register_shorten seen in shortening mode
      last = mask_reg[0] || (mode_shorten_reg && REGISTER_SHORTEN);
   end

   // sequencer, result and serial next values
   always @* begin
      state_next    = state_reg;
      mask_next     = mask_reg;
      result_next   = RESULT;
      sout_next     = SERIAL_OUT;
      eoc_flag_next = eoc_flag_reg;
      if (clear) begin
         // result, serial output and end flag forced to zero; the avalon outputs are left alone
         state_next    = ST_IDLE;
         mask_next     = {WIDTH{1'b0}};
         result_next   = {WIDTH{1'b0}};
         sout_next     = 1'b0;
         eoc_flag_next = 1'b0;
      end else if (start) begin
         // initial period: msb raised, serial inhibited
         state_next    = ST_TRIAL;
         mask_next     = {1'b1, {(WIDTH-1){1'b0}}};
         result_next   = {1'b1, {(WIDTH-1){1'b0}}};
         sout_next     = 1'b0;
         eoc_flag_next = 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               sout_next = 1'b0;
            end
            ST_TRIAL: begin
               // keep the bit on a high decision, clear on low
               result_next = decide(RESULT, mask_reg, cmp_dec);
               sout_next   = cmp_dec;
               mask_next   = next_mask(mask_reg);
               if (last) begin
                  state_next    = ST_DONE1;
                  eoc_flag_next = 1'b1;
               end
            end
            ST_DONE1: begin
               // inhibit stays off one more cycle: ninth serial bit
               sout_next  = cmp_dec;
               state_next = ST_DONE2;
            end
            ST_DONE2: begin
               sout_next  = 1'b0;
               state_next = ST_DONE;
            end
            ST_DONE: begin
               sout_next = 1'b0;
            end
            default: begin
               state_next    = ST_IDLE;
               mask_next     = {WIDTH{1'b0}};
               result_next   = {WIDTH{1'b0}};
               sout_next     = 1'b0;
               eoc_flag_next = 1'b0;
            end
         endcase
      end
   end

   // sequencer registers; decided bits hold outside the trial
   always @(posedge CLK) begin
      if (!RSTN) begin
         state_reg    <= ST_IDLE;
         mask_reg     <= {WIDTH{1'b0}};
         RESULT       <= {WIDTH{1'b0}};
         SERIAL_OUT   <= 1'b0;
         eoc_flag_reg <= 1'b0;
         sc_prev_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         mask_reg     <= mask_next;
         RESULT       <= result_next;
         SERIAL_OUT   <= sout_next;
         eoc_flag_reg <= eoc_flag_next;
         sc_prev_reg  <= START_CONVERT;
      end
   end

   // end flag moves to the output on the falling edge, after the data settle
   always @(negedge CLK) begin
      if (!RSTN) begin
         END_OF_CONVERT <= 1'b0;
      end else begin
         END_OF_CONVERT <= eoc_flag_reg;
      end
   end

   // avalon slave: one wait cycle, then the request is taken
   assign req  = AVS_READ || AVS_WRITE;
   assign take = req && !AVS_WAITREQUEST;

   always @(posedge CLK) begin
      if (!RSTN) begin
         AVS_WAITREQUEST  <= 1'b1;
         AVS_READDATA     <= 32'h00000000;
         mode_shorten_reg <= |(`SAR_CTRL_RESET & (32'h00000001 << `SAR_CTRL_MODE_BIT));
         soft_start_reg   <= 1'b0;
      end else begin
         AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST);
         soft_start_reg  <= 1'b0;
         // read data loaded as waitrequest drops, stable at the taking edge
         if (AVS_READ && AVS_WAITREQUEST) begin
            case (AVS_ADDRESS)
               `SAR_CTRL_OFS: begin
                  AVS_READDATA <= {31'h00000000, mode_shorten_reg};
               end
               `SAR_STATUS_OFS: begin
                  AVS_READDATA <= {21'h000000, SERIAL_OUT, state_reg == ST_TRIAL,
                                   END_OF_CONVERT, result_pad[7:0]};
               end
               default: begin
                  AVS_READDATA <= 32'h00000000;
               end
            endcase
         end
         // writes land at the taking edge; unmapped writes are dropped
         if (take && AVS_WRITE && AVS_ADDRESS == `SAR_CTRL_OFS) begin
            mode_shorten_reg <= AVS_WRITEDATA[`SAR_CTRL_MODE_BIT];
            soft_start_reg   <= AVS_WRITEDATA[`SAR_CTRL_START_BIT];
         end
      end
   end

endmodule // sar_core

`default_nettype wire

// file: sar_analog_model.sv
// comparator and converter loop model facing the register
`default_nettype none
module sar_analog_model (
   input  wire logic       clk,
   input  wire logic [7:0] result,
   input  wire logic [8:0] level,
   output var  logic       comp_data = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // converter output doubled to half steps, no offset, against the input level
   always @(posedge clk) begin
      comp_data <= level > {result, 1'b0};
   end
endmodule // sar_analog_model
`default_nettype wire

// file: sar_checker.sv
// assertions on the register pins and its register bus
`default_nettype none
module sar_checker #(
   parameter WIDTH = 8
) (
   input wire logic             CLK,
   input wire logic             RSTN,
   input wire logic             START_CONVERT,
   input wire logic             CLEAR_HOLD,
   input wire logic [WIDTH-1:0] RESULT,
   input wire logic             SERIAL_OUT,
   input wire logic             END_OF_CONVERT,
   input wire logic [3:0]       AVS_ADDRESS,
   input wire logic             AVS_READ,
   input wire logic             AVS_WRITE,
   input wire logic [31:0]      AVS_WRITEDATA,
   input wire logic             AVS_WAITREQUEST
);
   localparam logic [WIDTH-1:0] first_trial = {1'b1, {(WIDTH-1){1'b0}}};
   logic mode_reg;
   // variant select tracked from accepted writes
   always_ff @(posedge CLK) begin
      if (!RSTN)
         mode_reg <= 1'b0;
      else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0)
         mode_reg <= AVS_WRITEDATA[0];
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence s_start;
      !START_CONVERT ##1 (START_CONVERT && !(CLEAR_HOLD && !mode_reg));
   endsequence
   sequence s_run;
      s_start ##1 (!CLEAR_HOLD && !mode_reg && !$rose(START_CONVERT) && !AVS_WRITE)[*8];
   endsequence
   start_trial_a: assert property (s_start |=> RESULT == first_trial && !SERIAL_OUT)
      else $error("first trial not loaded");
   conv_end_a: assert property (s_run |=> END_OF_CONVERT && !$past(END_OF_CONVERT) && SERIAL_OUT == RESULT[0])
      else $error("end flag or last serial bit wrong");
   result_hold_a: assert property (END_OF_CONVERT && !START_CONVERT && !CLEAR_HOLD && !mode_reg
      && !AVS_WRITE && !$past(AVS_WRITE) |=> $stable(RESULT)) else $error("result changed after end");
   serial_inhibit_a: assert property ($rose(END_OF_CONVERT) && !START_CONVERT |-> ##2 !SERIAL_OUT)
      else $error("serial not inhibited");
   clear_out_a: assert property (CLEAR_HOLD && !mode_reg |=> RESULT == '0 && !SERIAL_OUT)
      else $error("clear ignored");
   clear_stay_a: assert property (RESULT == '0 && !END_OF_CONVERT && !START_CONVERT && !mode_reg
      && !AVS_WRITE && !$past(AVS_WRITE) |=> RESULT == '0) else $error("left cleared state");
   bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
      else $error("bus answer late");
   bus_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("wait low too long");
endmodule // sar_checker
bind sar_core sar_checker #(.WIDTH(WIDTH)) chk_i (.CLK(CLK), .RSTN(RSTN), .START_CONVERT(START_CONVERT),
   .CLEAR_HOLD(CLEAR_HOLD), .RESULT(RESULT), .SERIAL_OUT(SERIAL_OUT), .END_OF_CONVERT(END_OF_CONVERT),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

// file: testbench.sv
// self-checking bench for the successive approximation register
`default_nettype none
`include "sar_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rstn = 0, start_reg = 0, clear_hold = 0, free_run = 0, shorten_en = 0;
   logic        rd = 0, wr = 0, hi, serial_out, eoc, waitreq, comp_data;
   logic [3:0]  addr = 0;
   logic [31:0] wdata = 0, q, rdata;
   logic [8:0]  level = 0;
   logic [7:0]  result;
   integer      seed = 32'h6572;
   int          n_mismatch = 0, samples_checked = 0, cycles = 0;
   realtime     t0;
   wire         start_convert = free_run ? eoc : start_reg;
   wire         register_shorten = shorten_en & result[1];
   sar_core uut (.CLK(clk), .RSTN(rstn), .START_CONVERT(start_convert), .CLEAR_HOLD(clear_hold),
      .REGISTER_SHORTEN(register_shorten), .COMP_DATA(comp_data), .RESULT(result), .SERIAL_OUT(serial_out),
      .END_OF_CONVERT(eoc), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq));
   sar_analog_model far (.clk(clk), .result(result), .level(level), .comp_data(comp_data));
   always #2 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // one bus access, held until wait is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do @(posedge clk); while (waitreq !== 1'b0);
      r = rdata;
      rd <= 0;
      wr <= 0;
   endtask
   // expected word after k decisions: decided bits then the next trial bit
   function automatic logic [7:0] exp_res(input logic h, input int k);
      logic [7:0] m;
      m = 8'hff << (8 - k);
      return (h ? m : 8'h00) | (k < 8 ? 8'h80 >> k : 8'h00);
   endfunction
   task automatic set_level(input logic h);
      @(posedge clk);
      level <= h ? 9'h1ff : 9'h000;
      repeat (8) @(posedge clk);
   endtask
   task automatic run_conv(input logic h);
      set_level(h);
      start_reg <= 1;
      @(posedge clk);
      start_reg <= 0;
      for (int k = 0; k <= 8; k++) begin
         #1;
         chk(result, exp_res(h, k), "result");
         chk(serial_out, k ? h : 1'b0, "serial bit");
         chk(eoc & (k > 0), 0, "end early");
         if (k < 8)
            @(posedge clk);
      end
      @(negedge clk);
      #1 chk(eoc, 1, "end flag");
      @(posedge clk);
      #1 chk(serial_out, h, "ninth bit");
      @(posedge clk);
      #1 chk(serial_out, 0, "inhibit");
      chk(result, h ? 8'hff : 8'h00, "hold");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      chk(result, 0, "reset result");
      chk(waitreq, 1, "reset wait");
      rstn <= 1;
      bus(0, `SAR_CTRL_OFS, 0, q);
      chk(q, `SAR_CTRL_RESET, "ctrl reset");
      bus(1, 4'h8, 32'hffffffff, q);
      bus(0, 4'h8, 0, q);
      chk(q, 0, "unmapped");
      $display("test bus done");
      run_conv(1);
      run_conv(0);
      repeat (4) begin
         hi = 1'($random(seed));
         run_conv(hi);
      end
      bus(0, `SAR_STATUS_OFS, 0, q);
      chk(q[9:0], {2'b01, hi ? 8'hff : 8'h00}, "status");
      $display("test conversions done");
      set_level(1);
      start_reg <= 1;
      repeat (4) @(posedge clk);
      clear_hold <= 1;
      start_reg <= 0;
      @(posedge clk);
      clear_hold <= 0;
      #1 chk(result, 0, "clear");
      repeat (5) @(posedge clk);
      #1 chk(result, 0, "stay clear");
      chk(eoc, 0, "clear end flag");
      $display("test clear done");
      bus(1, `SAR_CTRL_OFS, 32'h2, q);
      for (int i = 0; i < 20 && eoc !== 1'b1; i++) @(posedge clk);
      bus(0, `SAR_STATUS_OFS, 0, q);
      chk(q[9:0], 10'h1ff, "soft start");
      free_run <= 1;
      @(posedge eoc);
      t0 = $realtime;
      @(posedge eoc);
      chk(32'(int'(($realtime - t0) / 4)), 9, "free run period");
      free_run <= 0;
      $display("test start modes done");
      set_level(0);
      bus(1, `SAR_CTRL_OFS, 32'h1, q);
      shorten_en <= 1;
      start_reg <= 1;
      @(posedge eoc);
      t0 = $realtime;
      @(posedge eoc);
      chk(($realtime - t0) < 36, 1, "short period");
      chk(result[7:2], 0, "short result");
      $display("test shortening done");
      end_sim();
   end
endmodule // testbench
`default_nettype wire
